// ### rsp_defs.vh
`ifndef RSP_DEFS_VH
`define RSP_DEFS_VH

`define RSP_ADDR_W         6
`define RSP_LAST_ADDR      6'h3F
`define RSP_FIRST_ADDR     6'h00
`define RSP_CLOCK_LAST     6'h07
`define RSP_CMD_WRITE      1'b1
`define RSP_BYTE_BITS      4'h8
`define RSP_BIT_CNT_RST    3'h0
`define RSP_BYTE_RST       8'h00
// recovery time in microseconds, converted at 200 MHz
`define RSP_REC_TIME_US    1000
`define RSP_CLK_MHZ        200
`define RSP_REC_CYCLES     (`RSP_REC_TIME_US * `RSP_CLK_MHZ)

`endif

// ### rsp_serial_port.v
// Overview of operation
// - selected only while select is low
// - msb first, first bit on first rise
// - sixty-four byte map, clock at 0-7
// - supply fail aborts, clears pointer, ignores inputs
// - after supply returns, inhibit for recovery
// - capture on rise, shift on fall
// - one clock per bit, bytes of eight
// - address bit 6 ignored
// - first bit direction, next seven address
// - one writes, zero reads
// - read drives output, write takes input
// - pointer increments per byte, bursts continue
// - pointer wraps 3Fh to 00h
// - freeze user copy on clock addresses
// - timekeeping keeps counting while frozen
// - supply fail deselects, asserts reset output
// - on battery, all outputs high impedance
// - reset output held through recovery
// - output undriven while deselected
// - falling select needed before any operation
// - output undriven until byte ready
`include "rsp_defs.vh"

module rsp_serial_port #(
    parameter REC_CYCLES = `RSP_REC_CYCLES
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       sck,
    input  wire       select_n,
    input  wire       serial_in,
    output reg        serial_out,
    output reg        serial_out_oe,
    input  wire       supply_fail,
    input  wire       on_battery,
    output reg        reset_out_n,
    output reg        reset_out_oe,
    output reg        copy_freeze,
    output reg  [5:0] mem_addr,
    output reg  [7:0] mem_wdata,
    output reg        mem_we,
    input  wire [7:0] mem_rdata,
    input  wire       mem_wready
);
    // two-flop synchronisers for every pin
    reg [1:0] sck_s;
    reg [1:0] sel_s;
    reg [1:0] din_s;
    reg [1:0] pf_s;
    reg [1:0] bat_s;
    reg       sck_d;
    reg       sel_d;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_s <= 2'b00;
            sel_s <= 2'b11;
            din_s <= 2'b00;
            pf_s  <= 2'b11;
            bat_s <= 2'b00;
            sck_d <= 1'b0;
            sel_d <= 1'b1;
        end else begin
            sck_s <= {sck_s[0], sck};
            sel_s <= {sel_s[0], select_n};
            din_s <= {din_s[0], serial_in};
            pf_s  <= {pf_s[0], supply_fail};
            bat_s <= {bat_s[0], on_battery};
            sck_d <= sck_s[1];
            sel_d <= sel_s[1];
        end
    end

    wire sck_rise = sck_s[1] && !sck_d;
    wire sck_fall = !sck_s[1] && sck_d;
    wire pfail    = pf_s[1];
    wire battery  = bat_s[1];

    // recovery inhibit after supply returns
    reg [31:0] rec_cnt;
    reg        inhibit;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_cnt <= 32'h0000_0000;
            inhibit <= 1'b1;
        end else if (pfail) begin
            rec_cnt <= 32'h0000_0000;
            inhibit <= 1'b1;
        end else if (inhibit) begin
            if (rec_cnt >= REC_CYCLES - 1)
                inhibit <= 1'b0;
            else
                rec_cnt <= rec_cnt + 32'h0000_0001;
        end
    end

    // armed only by a fresh falling select after inhibit ends
    reg  armed;
    wire sel_fall = sel_d && !sel_s[1];
    wire active   = armed && !sel_s[1] && !inhibit;

    always @(posedge clk or posedge rst) begin
        if (rst)
            armed <= 1'b0;
        else if (inhibit || sel_s[1])
            armed <= 1'b0;
        else if (sel_fall)
            armed <= 1'b1;
    end

    // transfer engine
    localparam ST_CMD  = 2'd0;
    localparam ST_DATA = 2'd1;

    reg [1:0] state;
    reg       is_write;
    reg [2:0] bit_cnt;
    reg [7:0] shreg;
    reg [5:0] ptr;
    reg [7:0] tx;
    reg       tx_live;

    // write commits pass a two-entry buffer to the memory port
    reg         wb_valid;
    reg  [13:0] wb_data;
    wire        wb_ready;
    wire [13:0] wq_data;
    wire        wq_valid;

    rsp_skid_buffer #(
        .WIDTH (14)
    ) u_wbuf (
        .clk       (clk),
        .rst       (rst),
        .in_data   (wb_data),
        .in_valid  (wb_valid),
        .in_ready  (wb_ready),
        .out_data  (wq_data),
        .out_valid (wq_valid),
        .out_ready (mem_wready)
    );

    wire [7:0] byte_in   = {shreg[6:0], din_s[1]};
    wire       byte_done = sck_rise && (bit_cnt == 3'd7);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= ST_CMD;
            is_write <= 1'b0;
            bit_cnt  <= `RSP_BIT_CNT_RST;
            shreg    <= `RSP_BYTE_RST;
            ptr      <= `RSP_FIRST_ADDR;
            tx       <= `RSP_BYTE_RST;
            tx_live  <= 1'b0;
            wb_valid <= 1'b0;
            wb_data  <= 14'h0000;
        end else begin
            if (wb_valid && wb_ready)
                wb_valid <= 1'b0;
            if (!active) begin
                // deselect or supply fail drops any partial byte
                state   <= ST_CMD;
                bit_cnt <= `RSP_BIT_CNT_RST;
                tx_live <= 1'b0;
                if (pfail)
                    ptr <= `RSP_FIRST_ADDR;
            end else begin
                if (sck_rise) begin
                    shreg   <= byte_in;
                    bit_cnt <= bit_cnt + 3'd1;
                end
                if (byte_done) begin
                    case (state)
                        ST_CMD: begin
                            is_write <= (byte_in[7] == `RSP_CMD_WRITE);
                            ptr      <= byte_in[5:0];
                            state    <= ST_DATA;
                        end
                        ST_DATA: begin
                            if (is_write) begin
                                // stall risk: two slots plus wb_data absorb three bytes; a fourth byte while stalled overwrites wb_data
                                wb_data  <= {ptr, byte_in};
                                wb_valid <= 1'b1;
                            end
                            ptr <= (ptr == `RSP_LAST_ADDR) ?
                                   `RSP_FIRST_ADDR : ptr + 6'd1;
                        end
                        default: state <= ST_CMD;
                    endcase
                end
                // read byte loads on the fall after a full byte
                if (sck_fall && !is_write && state == ST_DATA) begin
                    if (bit_cnt == 3'd0) begin
                        tx      <= mem_rdata;
                        tx_live <= 1'b1;
                    end else begin
                        tx <= {tx[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // outputs, all registered
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
            reset_out_n   <= 1'b0;
            reset_out_oe  <= 1'b0;
            copy_freeze   <= 1'b0;
            mem_addr      <= `RSP_FIRST_ADDR;
            mem_wdata     <= `RSP_BYTE_RST;
            mem_we        <= 1'b0;
        end else begin
            serial_out    <= tx[7];
            serial_out_oe <= tx_live && active && !battery;
            // open drain: drive low while failing or recovering
            reset_out_n   <= 1'b0;
            reset_out_oe  <= (pfail || inhibit) && !battery;
            // timekeeping lives elsewhere and keeps counting; only copy stops
            copy_freeze   <= active && state == ST_DATA &&
                             ptr <= `RSP_CLOCK_LAST;
            mem_addr      <= wq_valid ? wq_data[13:8] : ptr;
            mem_wdata     <= wq_data[7:0];
            mem_we        <= wq_valid && mem_wready;
        end
    end
endmodule // rsp_serial_port

// ### rsp_serial_port_sva.sv
module rsp_serial_port_sva #(
    parameter int REC_CYCLES = 200000
) (
    input logic       clk,
    input logic       rst,
    input logic       select_n,
    input logic       supply_fail,
    input logic       on_battery,
    input logic       serial_out,
    input logic       serial_out_oe,
    input logic       reset_out_n,
    input logic       reset_out_oe,
    input logic       copy_freeze,
    input logic [5:0] mem_addr,
    input logic [7:0] mem_rdata,
    input logic       mem_we
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    int cnt;
    // margins absorb the pin synchronisers
    always @(posedge clk or posedge rst)
        if (rst)
            cnt <= 0;
        else if (supply_fail)
            cnt <= 0;
        else if (cnt < REC_CYCLES + 8)
            cnt <= cnt + 1;
    chk_rec_hold: assert property (cnt >= 4 && cnt < REC_CYCLES - 2 && !on_battery |-> reset_out_oe)
        else $error("reset output released early");
    chk_rec_end: assert property (cnt == REC_CYCLES + 8 && !on_battery |-> !reset_out_oe)
        else $error("reset output held too long");
    chk_fail_reset: assert property (supply_fail [*4] ##0 !on_battery |-> reset_out_oe)
        else $error("reset output not raised on supply fail");
    chk_fail_quiet: assert property (supply_fail [*4] |-> !serial_out_oe)
        else $error("output driven during supply fail");
    chk_batt_hiz: assert property (on_battery [*4] |-> !serial_out_oe && !reset_out_oe)
        else $error("output driven on battery");
    chk_desel_idle: assert property (select_n [*8] |-> !serial_out_oe && !copy_freeze)
        else $error("output or freeze active while deselected");
    chk_od_low: assert property (reset_out_oe |-> !reset_out_n)
        else $error("reset output drives high");
    chk_freeze_range: assert property (copy_freeze && !mem_we && !$past(mem_we)
        |-> mem_addr <= 6'h07 || $past(mem_addr) <= 6'h07)
        else $error("freeze outside clock locations");
    chk_read_msb: assert property ($rose(serial_out_oe) |-> serial_out == $past(mem_rdata[7]))
        else $error("first read bit is not the msb");
endmodule // rsp_serial_port_sva

// ### rsp_serial_port_tb.sv
module rsp_serial_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int REC = 400;
    logic       clk, rst, sck, select_n, serial_in, serial_out, serial_out_oe;
    logic       supply_fail, on_battery, reset_out_n, reset_out_oe, copy_freeze;
    logic       mem_we, mem_wready, stall;
    logic [5:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata, r;
    logic [7:0] mem [64];
    logic [7:0] exp_mem [64];
    int         failures, cmp_count, n0;
    int         we_count = 0;
    int         seed = 53472;
    int         wseed = 11;
    rsp_serial_port #(.REC_CYCLES(REC)) i_dut (.clk(clk), .rst(rst), .sck(sck),
        .select_n(select_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .supply_fail(supply_fail), .on_battery(on_battery),
        .reset_out_n(reset_out_n), .reset_out_oe(reset_out_oe), .copy_freeze(copy_freeze),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .mem_rdata(mem_rdata), .mem_wready(mem_wready));
    rsp_spi_master i_m (.sck(sck), .select_n(select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    assign mem_rdata = mem[mem_addr];
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        mem_wready <= stall ? 1'b0 : ($random(wseed) % 4) != 0;
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
            we_count <= we_count + 1;
        end
    end
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wr(input logic [6:0] a, input int n, input bit live);
        logic [7:0] d;
        logic [5:0] p;
        p = a[5:0];
        i_m.start(1'($random(seed)));
        i_m.bits({1'b1, a}, 8, r);
        repeat (n) begin
            d = 8'($random(seed));
            i_m.bits(d, 8, r);
            if (live)
                exp_mem[p] = d;
            p++;
        end
        i_m.stop();
        repeat (10) @(posedge clk);
    endtask
    task automatic rd(input logic [6:0] a, input int n);
        logic [5:0] p;
        p = a[5:0];
        i_m.start(1'($random(seed)));
        i_m.bits({1'b0, a}, 8, r);
        repeat (n) begin
            i_m.bits(8'($random(seed)), 8, r);
            check("read byte", exp_mem[p], r);
            p++;
        end
        i_m.stop();
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        rst = 1;
        stall = 0;
        supply_fail = 0;
        on_battery = 0;
        for (int i = 0; i < 64; i++) begin
            mem[i] = 8'(i);
            exp_mem[i] = 8'(i);
        end
        repeat (12) @(posedge clk);
        rst <= 0;
        repeat (REC / 2) @(posedge clk);
        check("oe in recovery", 8'h01, {7'h00, reset_out_oe});
        repeat (REC) @(posedge clk);
        check("oe after recovery", 8'h00, {7'h00, reset_out_oe});
        wr(7'h46, 4, 1);
        wr(7'h3E, 4, 1);
        repeat (6) wr(7'($random(seed)), 1 + $unsigned($random(seed)) % 5, 1);
        // receiver stalls through a whole burst, both words must survive
        stall <= 1;
        wr(7'h20, 2, 1);
        stall <= 0;
        repeat (10) @(posedge clk);
        i_m.start(0);
        i_m.bits(8'h90, 8, r);
        i_m.bits(8'ha5, 4, r);
        i_m.stop();
        rd(7'h30, 40);
        // clock locations freeze the user copy, pointer at 08h releases it
        i_m.start(0);
        i_m.bits({1'b0, 7'h06}, 8, r);
        repeat (6) @(posedge clk);
        check("freeze on clock", 8'h01, {7'h00, copy_freeze});
        i_m.bits(8'h00, 8, r);
        check("read byte", exp_mem[6], r);
        i_m.bits(8'h00, 8, r);
        check("read byte", exp_mem[7], r);
        repeat (6) @(posedge clk);
        check("freeze past clock", 8'h00, {7'h00, copy_freeze});
        i_m.stop();
        $display("test write and read done");
        n0 = we_count;
        supply_fail <= 1;
        repeat (8) @(posedge clk);
        check("oe in fail", 8'h01, {7'h00, reset_out_oe});
        wr(7'h15, 2, 0);
        on_battery <= 1;
        repeat (8) @(posedge clk);
        check("oe on battery", 8'h00, {6'h00, reset_out_oe, serial_out_oe});
        on_battery <= 0;
        supply_fail <= 0;
        wr(7'h16, 1, 0);
        check("writes while protected", 8'(n0), 8'(we_count));
        repeat (REC) @(posedge clk);
        rd(7'h00, 64);
        $display("test supply fail done");
        end_of_test;
    end
    initial begin
        #400us;
        failures++;
        end_of_test;
    end
endmodule // rsp_serial_port_tb
bind rsp_serial_port rsp_serial_port_sva #(.REC_CYCLES(REC_CYCLES)) i_chk (.clk(clk), .rst(rst),
    .select_n(select_n), .supply_fail(supply_fail), .on_battery(on_battery),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .reset_out_n(reset_out_n),
    .reset_out_oe(reset_out_oe), .copy_freeze(copy_freeze), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_we(mem_we));

// ### rsp_skid_buffer.v
module rsp_skid_buffer #(
    parameter WIDTH = 14
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] slot0;
    reg [WIDTH-1:0] slot1;
    reg [1:0]       count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data  = slot0;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slot0 <= {WIDTH{1'b0}};
            slot1 <= {WIDTH{1'b0}};
            count <= 2'd0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'd0)
                        slot0 <= in_data;
                    else
                        slot1 <= in_data;
                    count <= count + 2'd1;
                end
                2'b01: begin
                    slot0 <= slot1;
                    count <= count - 2'd1;
                end
                2'b11: begin
                    if (count == 2'd1)
                        slot0 <= in_data;
                    else begin
                        slot0 <= slot1;
                        slot1 <= in_data;
                    end
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end
endmodule // rsp_skid_buffer

// ### rsp_spi_master.sv
module rsp_spi_master (
    output logic sck,
    output logic select_n,
    output logic serial_in,
    input  logic serial_out,
    input  logic serial_out_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    bit cpol;
    initial begin
        sck = 0;
        select_n = 1;
        serial_in = 0;
    end
    task automatic start(input bit mode);
        cpol = mode;
        #0.7 sck <= mode;
        #200 select_n <= 0;
        #200;
    endtask
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            sck <= 0;
            serial_in <= tx[i];
            #32 sck <= 1;
            rx[i] = serial_out_oe ? serial_out : 1'bz;
            #32;
        end
    endtask
    task automatic stop;
        #200 sck <= cpol;
        // released line must not look like the last bit
        serial_in <= ~serial_in;
        #20 select_n <= 1;
        #250;
    endtask
endmodule // rsp_spi_master
